// ==== src/scd_decoder.sv ====
// Card-side command decoder for the serial link, commands 26 to 63 and
// block length handling. Link logic runs on SPI_SCK; decoding on CLK_SYS.
// Assumes the host waits for each answer before sending the next command.
`timescale 1ns/10ps
// Behaviour
// - Writes are accepted only with a 512-byte block length.
// - Read block length may be anything from 1 to 512 bytes.
// - Write with block length below 512 is refused with an error flag.
// - Block length is 512 bytes after reset.
// - Single write: data response token, then busy until programming ends unless the data CRC is bad.
// - Command 27 requests card-data programming and answers one R1 byte.
// - Commands 28 and 29 change nothing; no protect groups exist.
// - Command 30 returns 32 protect bits plus 16 CRC bits.
// - Command 32 latches the first erase block address.
// - Command 33 latches the last erase block address.
// - Command 38 erases the latched range, answers R1 then busy.
// - Command 55 answers R1 and marks next command as application.
// - Command 56 bit 0 picks data direction; size is block length.
// - Command 58 returns operating conditions in a five-byte answer.
// - Command 59 bit 0 turns CRC checking on or off.
// - Don't-care argument bits are always sent and ignored.
// - Unsupported or reserved indices set the illegal-command flag.
// - R1 is one byte, MSB first, top bit zero, bit 0 flags idle, other ones flag errors.
// - Busy sends zero bytes; first non-zero byte means ready.
module scd_decoder
    import scd_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RST_N,
    input  wire logic        SPI_SCK,
    input  wire logic        SPI_CS_N,
    input  wire logic        SPI_MOSI,
    output logic             SPI_MISO,
    output logic             SPI_MISO_OE,
    input  wire logic [31:0] OCR_VALUE,
    input  wire logic        WR_DONE,
    input  wire logic        WR_CRC_BAD,
    input  wire logic        PROG_DONE,
    output logic             ERASE_REQ,
    output logic [31:0]      ERASE_FIRST,
    output logic [31:0]      ERASE_LAST,
    output logic             CSD_PROG_REQ,
    output logic             RD_REQ,
    output logic             WR_REQ,
    output logic             GEN_REQ,
    output logic             GEN_DIR,
    output logic [31:0]      XFER_ADDR,
    output logic [9:0]       BLOCK_LEN,
    output logic             CRC_EN,
    output logic             APP_PENDING,
    output logic             ACMD_REQ,
    output logic [5:0]       ACMD_INDEX,
    output logic [31:0]      ACMD_ARG,
    output logic             CARD_BUSY
);

    function automatic logic [7:0] scd_flag(input logic [2:0] pos);
        return 8'(8'h01 << pos);
    endfunction : scd_flag

    scd_sys_t  s;
    scd_sys_t  next_s;
    scd_link_t l;
    scd_link_t next_l;

    logic        cmd_q;
    logic [1:0]  to_link;
    logic [1:0]  at_link;
    logic        cmd_new;
    logic [5:0]  idx;
    logic [31:0] arg;
    logic        take;

    // Link to system: command toggle
    scd_sync u_cmd_sync (
        .CLK   (CLK_SYS),
        .RST_N (RST_N),
        .D     (l.cmd_tgl),
        .Q     (cmd_q)
    );

    // System to link: answer toggle and busy level
    assign to_link = {s.busy, s.resp_tgl};
    for (genvar g = 0; g < 2; g++) begin : g_to_link
        scd_sync u_sync (
            .CLK   (SPI_SCK),
            .RST_N (RST_N),
            .D     (to_link[g]),
            .Q     (at_link[g])
        );
    end

    // Command word is stable in the link domain once its toggle is seen
    assign cmd_new = cmd_q ^ s.cmd_prev;
    assign idx     = l.cmd_word[IDX_HI:IDX_LO];
    assign arg     = l.cmd_word[ARG_HI:ARG_LO];
    assign take    = cmd_new && (s.fsm == SCD_IDLE);

    // ---------------- System domain ----------------
    always_comb begin
        logic [7:0]  r1;
        logic [55:0] tail;
        logic [3:0]  len;
        r1   = 8'h00;
        tail = '0;
        len  = LEN_R1;
        next_s           = s;
        next_s.cmd_prev  = cmd_q;
        next_s.erase_req = 1'b0;
        next_s.csd_req   = 1'b0;
        next_s.rd_req    = 1'b0;
        next_s.wr_req    = 1'b0;
        next_s.gen_req   = 1'b0;
        next_s.acmd_req  = 1'b0;
        case (s.fsm)
            SCD_IDLE: begin
                // Commands arriving in other states are dropped
                if (cmd_new) begin
                    if (s.app_pend) begin
                        next_s.acmd_req = 1'b1;
                        next_s.acmd_idx = idx;
                        next_s.acmd_arg = arg;
                        next_s.app_pend = 1'b0;
                    end else begin
                        case (idx)
                            CMD_GO_IDLE: begin
                                next_s.blk_len    = BLK_LEN_RST;
                                next_s.crc_en     = 1'b0;
                                next_s.have_first = 1'b0;
                                next_s.have_last  = 1'b0;
                                r1 = scd_flag(R1_IDLE);
                            end
                            CMD_SET_LEN: begin
                                if (arg == 32'h0 || arg > BLK_LEN_MAX) begin
                                    r1 = scd_flag(R1_PARAM);
                                end else begin
                                    next_s.blk_len = arg[9:0];
                                end
                            end
                            CMD_RD_SINGLE: begin
                                next_s.rd_req    = 1'b1;
                                next_s.xfer_addr = arg;
                            end
                            CMD_WR_SINGLE: begin
                                if (s.blk_len != BLK_LEN_WRITE) begin
                                    r1 = scd_flag(R1_PARAM);
                                end else if ((arg[8:0] & SECTOR_MASK) != 9'h0)
                                begin
                                    r1 = scd_flag(R1_ADDR);
                                end else begin
                                    next_s.wr_req    = 1'b1;
                                    next_s.xfer_addr = arg;
                                    next_s.fsm       = SCD_WDATA;
                                end
                            end
                            CMD_PROG_CSD: begin
                                next_s.csd_req = 1'b1;
                            end
                            CMD_SET_PROT, CMD_CLR_PROT: begin
                                // No protect groups: nothing to change
                                r1 = 8'h00;
                            end
                            CMD_QRY_PROT: begin
                                tail = {TOK_START, PROT_BITS,
                                        PROT_CRC};
                                len  = LEN_PROT;
                            end
                            CMD_ERASE_FIRST: begin
                                next_s.first      = arg;
                                next_s.have_first = 1'b1;
                            end
                            CMD_ERASE_LAST: begin
                                next_s.last      = arg;
                                next_s.have_last = 1'b1;
                            end
                            CMD_ERASE: begin
                                if (s.have_first && s.have_last) begin
                                    next_s.erase_req  = 1'b1;
                                    next_s.busy       = 1'b1;
                                    next_s.fsm        = SCD_BUSY;
                                end else begin
                                    r1 = scd_flag(R1_ERASE_SEQ);
                                end
                                next_s.have_first = 1'b0;
                                next_s.have_last  = 1'b0;
                            end
                            CMD_APP_PREFIX: begin
                                next_s.app_pend = 1'b1;
                            end
                            CMD_GENERAL: begin
                                next_s.gen_req = 1'b1;
                                next_s.gen_dir = arg[0];
                            end
                            CMD_READ_OPERATING_CONDITIONS: begin
                                tail = {OCR_VALUE, 24'h0};
                                len  = LEN_R3;
                            end
                            CMD_CRC_OPT: begin
                                next_s.crc_en = arg[0];
                            end
                            default: begin
                                r1 = scd_flag(R1_ILLEGAL);
                            end
                        endcase
                    end
                    next_s.resp     = {r1, tail};
                    next_s.resp_len = len;
                    next_s.resp_tgl = ~s.resp_tgl;
                end
            end
            SCD_WDATA: begin
                if (WR_DONE) begin
                    next_s.resp_len = LEN_R1;
                    next_s.resp_tgl = ~s.resp_tgl;
                    if (WR_CRC_BAD) begin
                        next_s.resp = {TOK_DATA_CRC, 56'h0};
                        next_s.fsm  = SCD_IDLE;
                    end else begin
                        next_s.resp = {TOK_DATA_OK, 56'h0};
                        next_s.busy = 1'b1;
                        next_s.fsm  = SCD_BUSY;
                    end
                end
            end
            SCD_BUSY: begin
                if (PROG_DONE) begin
                    next_s.busy = 1'b0;
                    next_s.fsm  = SCD_IDLE;
                end
            end
            default: begin
                next_s.fsm = SCD_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            s         <= '0;
            s.fsm     <= SCD_IDLE;
            s.blk_len <= BLK_LEN_RST;
        end else begin
            s <= next_s;
        end
    end

    // ---------------- Link domain ----------------
    always_comb begin
        logic [7:0] rx_byte;
        logic       resp_edge;
        rx_byte          = {l.rx[6:0], SPI_MOSI};
        resp_edge        = at_link[0] ^ l.resp_prev;
        next_l           = l;
        next_l.resp_prev = at_link[0];
        // Extra stage keeps busy fill from overtaking the answer
        next_l.busy_d    = at_link[1];
        if (resp_edge) begin
            next_l.txbuf   = s.resp;
            next_l.tx_left = s.resp_len;
        end
        if (SPI_CS_N) begin
            next_l.bit_cnt   = 3'h0;
            next_l.frame_cnt = 3'h0;
            next_l.tx        = FILL_IDLE;
        end else begin
            next_l.rx      = rx_byte;
            next_l.bit_cnt = 3'(l.bit_cnt + 3'h1);
            if (l.bit_cnt == 3'h7) begin
                if (l.frame_cnt == 3'h0) begin
                    if (rx_byte[7:6] == FRAME_START) begin
                        next_l.frame     = {l.frame[31:0], rx_byte};
                        next_l.frame_cnt = 3'h1;
                    end
                end else if (l.frame_cnt == FRAME_LAST_BYTE) begin
                    next_l.cmd_word  = {l.frame, rx_byte};
                    next_l.cmd_tgl   = ~l.cmd_tgl;
                    next_l.frame_cnt = 3'h0;
                end else begin
                    next_l.frame     = {l.frame[31:0], rx_byte};
                    next_l.frame_cnt = 3'(l.frame_cnt + 3'h1);
                end
                if (resp_edge) begin
                    next_l.tx      = s.resp[63:56];
                    next_l.txbuf   = {s.resp[55:0], 8'hFF};
                    next_l.tx_left = 4'(s.resp_len - 4'h1);
                end else if (l.tx_left != 4'h0) begin
                    next_l.tx      = l.txbuf[63:56];
                    next_l.txbuf   = {l.txbuf[55:0], 8'hFF};
                    next_l.tx_left = 4'(l.tx_left - 4'h1);
                end else if (l.busy_d) begin
                    next_l.tx = FILL_BUSY;
                end else begin
                    next_l.tx = FILL_IDLE;
                end
            end else begin
                next_l.tx = {l.tx[6:0], 1'b1};
            end
        end
    end

    always_ff @(posedge SPI_SCK or negedge RST_N) begin
        if (!RST_N) begin
            l    <= '0;
            l.tx <= FILL_IDLE;
        end else begin
            l <= next_l;
        end
    end

    assign SPI_MISO     = l.tx[7];
    assign SPI_MISO_OE  = ~SPI_CS_N;
    assign ERASE_REQ    = s.erase_req;
    assign ERASE_FIRST  = s.first;
    assign ERASE_LAST   = s.last;
    assign CSD_PROG_REQ = s.csd_req;
    assign RD_REQ       = s.rd_req;
    assign WR_REQ       = s.wr_req;
    assign GEN_REQ      = s.gen_req;
    assign GEN_DIR      = s.gen_dir;
    assign XFER_ADDR    = s.xfer_addr;
    assign BLOCK_LEN    = s.blk_len;
    assign CRC_EN       = s.crc_en;
    assign APP_PENDING  = s.app_pend;
    assign ACMD_REQ     = s.acmd_req;
    assign ACMD_INDEX   = s.acmd_idx;
    assign ACMD_ARG     = s.acmd_arg;
    assign CARD_BUSY    = s.busy;

    // ---------------- Checks ----------------
    property p_len_range;
        @(posedge CLK_SYS) disable iff (!RST_N)
        s.blk_len != 10'h0 && s.blk_len <= BLK_LEN_RST;
    endproperty
    a_len_range: assert property (p_len_range)
        else $error("block length out of range");

    property p_short_write;
        @(posedge CLK_SYS) disable iff (!RST_N)
        take && !s.app_pend && idx == CMD_WR_SINGLE
            && s.blk_len != BLK_LEN_WRITE
        |=> !s.wr_req && s.resp[63:56] == scd_flag(R1_PARAM)
            && s.fsm == SCD_IDLE;
    endproperty
    a_short_write: assert property (p_short_write)
        else $error("short block write not refused");

    property p_reset_len;
        @(posedge CLK_SYS) disable iff (!RST_N)
        take && !s.app_pend && idx == CMD_GO_IDLE |=> s.blk_len == BLK_LEN_RST;
    endproperty
    a_reset_len: assert property (p_reset_len)
        else $error("block length not restored");

    property p_write_busy;
        @(posedge CLK_SYS) disable iff (!RST_N)
        s.fsm == SCD_WDATA && WR_DONE && !WR_CRC_BAD
        |=> s.resp[63:56] == TOK_DATA_OK && s.busy && s.fsm == SCD_BUSY;
    endproperty
    a_write_busy: assert property (p_write_busy)
        else $error("write token or busy wrong");

    // Busy may only drop on the programming-done pulse
    property p_busy_hold;
        @(posedge CLK_SYS) disable iff (!RST_N)
        s.fsm == SCD_BUSY && !PROG_DONE |=> s.busy && s.fsm == SCD_BUSY;
    endproperty
    a_busy_hold: assert property (p_busy_hold)
        else $error("busy dropped before programming ended");

    property p_query;
        @(posedge CLK_SYS) disable iff (!RST_N)
        take && !s.app_pend && idx == CMD_QRY_PROT
        |=> s.resp_len == LEN_PROT && s.resp[55:48] == TOK_START
            && s.resp[47:0] == {PROT_BITS, PROT_CRC};
    endproperty
    a_query: assert property (p_query)
        else $error("protect status answer wrong");

    property p_erase_range;
        @(posedge CLK_SYS) disable iff (!RST_N)
        take && !s.app_pend && idx == CMD_ERASE_FIRST
        |=> s.first == $past(arg) && s.have_first;
    endproperty
    a_erase_range: assert property (p_erase_range)
        else $error("erase start not latched");

    property p_erase;
        @(posedge CLK_SYS) disable iff (!RST_N)
        take && !s.app_pend && idx == CMD_ERASE && s.have_first && s.have_last
        |=> s.erase_req && s.busy && s.resp[63:56] == 8'h00 ##1 !s.erase_req;
    endproperty
    a_erase: assert property (p_erase)
        else $error("erase not started");

    property p_app;
        @(posedge CLK_SYS) disable iff (!RST_N)
        take && s.app_pend |=> s.acmd_req && !s.app_pend;
    endproperty
    a_app: assert property (p_app)
        else $error("application prefix not consumed");

    property p_crc;
        @(posedge CLK_SYS) disable iff (!RST_N)
        take && !s.app_pend && idx == CMD_CRC_OPT
        |=> s.crc_en == $past(arg[0]);
    endproperty
    a_crc: assert property (p_crc)
        else $error("CRC option not applied");

    property p_illegal;
        @(posedge CLK_SYS) disable iff (!RST_N)
        take && !s.app_pend && (idx == 6'h1A || idx == 6'h27 || idx == 6'h39)
        |=> s.resp[63:56] == scd_flag(R1_ILLEGAL);
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("illegal command not flagged");

endmodule : scd_decoder

// ==== src/scd_pkg.sv ====
// Shared constants and state types for the card command decoder.
// Assumes a byte-framed serial link and a flash back end on the system clock.
package scd_pkg;

    // Command indices
    localparam logic [5:0] CMD_GO_IDLE     = 6'h00;
    localparam logic [5:0] CMD_SET_LEN     = 6'h10;
    localparam logic [5:0] CMD_RD_SINGLE   = 6'h11;
    localparam logic [5:0] CMD_WR_SINGLE   = 6'h18;
    localparam logic [5:0] CMD_PROG_CSD    = 6'h1B;
    localparam logic [5:0] CMD_SET_PROT    = 6'h1C;
    localparam logic [5:0] CMD_CLR_PROT    = 6'h1D;
    localparam logic [5:0] CMD_QRY_PROT    = 6'h1E;
    localparam logic [5:0] CMD_ERASE_FIRST = 6'h20;
    localparam logic [5:0] CMD_ERASE_LAST  = 6'h21;
    localparam logic [5:0] CMD_ERASE       = 6'h26;
    localparam logic [5:0] CMD_APP_PREFIX  = 6'h37;
    localparam logic [5:0] CMD_GENERAL     = 6'h38;
    localparam logic [5:0] CMD_READ_OPERATING_CONDITIONS    = 6'h3A;
    localparam logic [5:0] CMD_CRC_OPT     = 6'h3B;

    // Command frame layout
    localparam logic [2:0] FRAME_LAST_BYTE = 3'h5;
    localparam logic [1:0] FRAME_START     = 2'h1;
    localparam int         IDX_HI          = 45;
    localparam int         IDX_LO          = 40;
    localparam int         ARG_HI          = 39;
    localparam int         ARG_LO          = 8;

    // Block length
    localparam logic [9:0]  BLK_LEN_RST    = 10'h200;
    localparam logic [9:0]  BLK_LEN_WRITE  = 10'h200;
    localparam logic [31:0] BLK_LEN_MAX    = 32'h0000_0200;
    localparam logic [8:0]  SECTOR_MASK    = 9'h1FF;

    // Response byte 1 flag positions
    localparam logic [2:0] R1_IDLE      = 3'h0;
    localparam logic [2:0] R1_ILLEGAL   = 3'h2;
    localparam logic [2:0] R1_ERASE_SEQ = 3'h4;
    localparam logic [2:0] R1_ADDR      = 3'h5;
    localparam logic [2:0] R1_PARAM     = 3'h6;

    // Tokens, fill bytes and protect-status answer fields
    localparam logic [7:0]  TOK_START    = 8'hFE;
    localparam logic [7:0]  TOK_DATA_OK  = 8'h05;
    localparam logic [7:0]  TOK_DATA_CRC = 8'h0B;
    localparam logic [7:0]  FILL_IDLE    = 8'hFF;
    localparam logic [7:0]  FILL_BUSY    = 8'h00;
    localparam logic [31:0] PROT_BITS    = 32'h0000_0000;
    localparam logic [15:0] PROT_CRC     = 16'h0000;

    // Response lengths in bytes
    localparam logic [3:0] LEN_R1   = 4'h1;
    localparam logic [3:0] LEN_R3   = 4'h5;
    localparam logic [3:0] LEN_PROT = 4'h8;

    typedef enum logic [2:0] {
        SCD_IDLE  = 3'h1,
        SCD_WDATA = 3'h2,
        SCD_BUSY  = 3'h4
    } scd_state_t;

    typedef struct packed {
        scd_state_t  fsm;
        logic [9:0]  blk_len;
        logic [31:0] first;
        logic [31:0] last;
        logic        have_first;
        logic        have_last;
        logic        app_pend;
        logic        crc_en;
        logic        gen_dir;
        logic [31:0] xfer_addr;
        logic [63:0] resp;
        logic [3:0]  resp_len;
        logic        resp_tgl;
        logic        busy;
        logic        cmd_prev;
        logic        erase_req;
        logic        csd_req;
        logic        rd_req;
        logic        wr_req;
        logic        gen_req;
        logic        acmd_req;
        logic [5:0]  acmd_idx;
        logic [31:0] acmd_arg;
    } scd_sys_t;

    typedef struct packed {
        logic [7:0]  rx;
        logic [2:0]  bit_cnt;
        logic [2:0]  frame_cnt;
        logic [39:0] frame;
        logic [47:0] cmd_word;
        logic        cmd_tgl;
        logic [7:0]  tx;
        logic [63:0] txbuf;
        logic [3:0]  tx_left;
        logic        resp_prev;
        logic        busy_d;
    } scd_link_t;

endpackage : scd_pkg

// ==== src/scd_sync.sv ====
// Two-stage level synchroniser.
// Assumes D is a level from another clock domain held for several edges.
`timescale 1ns/10ps
module scd_sync (
    input  wire logic CLK,
    input  wire logic RST_N,
    input  wire logic D,
    output logic      Q
);
    typedef struct packed {
        logic meta;
        logic q;
    } scd_sync_t;

    scd_sync_t s;
    scd_sync_t next_s;

    always_comb begin
        next_s.meta = D;
        next_s.q    = s.meta;
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign Q = s.q;
endmodule : scd_sync

// ==== tb/scd_host_model.sv ====
// Host end of the serial link: frames commands and clocks answers in.
// Assumes one caller at a time; the link clock is idle between calls.
`timescale 1ns/10ps
module scd_host_model (
    output logic      SPI_SCK,
    output logic      SPI_CS_N,
    output logic      SPI_MOSI,
    input  wire logic SPI_MISO
);
    initial begin
        SPI_SCK = 1'b0;
        SPI_CS_N = 1'b1;
        SPI_MOSI = 1'b1;
    end
    // Card shifts after the rising edge, so sample late in the high phase
    task automatic tick(input logic m, output logic s);
        SPI_MOSI = m;
        #16 SPI_SCK = 1'b1;
        #15 s = SPI_MISO;
        #1 SPI_SCK = 1'b0;
    endtask : tick
    task automatic send(input logic [5:0] idx, input logic [31:0] arg);
        logic [47:0] f;
        logic        s;
        f = {2'b01, idx, arg, 8'h01};
        SPI_CS_N = 1'b0;
        for (int i = 47; i >= 0; i--) tick(f[i], s);
    endtask : send
    // Bitwise hunt for the leading zero, so byte alignment is not assumed
    task automatic recv(input int n, output logic [63:0] v);
        logic s;
        int   k;
        s = 1'b1;
        k = 0;
        v = '0;
        while (s !== 1'b0 && k < 64) begin
            tick(1'b1, s);
            k++;
        end
        for (int i = 0; i < n; i++) begin
            if (i > 0) tick(1'b1, s);
            v = {v[62:0], s};
        end
    endtask : recv
    // Trailing clocks with select high let the card drop its framing
    task automatic done();
        logic s;
        SPI_CS_N = 1'b1;
        repeat (8) tick(1'b1, s);
    endtask : done
    task automatic ready(output logic ok);
        logic s;
        int   k;
        s = 1'b0;
        k = 0;
        while (s !== 1'b1 && k < 4000) begin
            tick(1'b1, s);
            k++;
        end
        ok = s;
        done();
    endtask : ready
endmodule : scd_host_model

// ==== tb/test_scd_decoder.sv ====
// Self-checking bench for the card command decoder.
// Assumes the host model owns the link; flash pulses come from here.
`timescale 1ns/10ps
module test_scd_decoder
    import scd_pkg::*;
;
    logic        CLK_SYS = 1'b0;
    logic        RST_N = 1'b0;
    logic        WR_DONE = 1'b0;
    logic        WR_CRC_BAD = 1'b0;
    logic        PROG_DONE = 1'b0;
    logic [31:0] OCR_VALUE = 32'hC0FF_8000;
    logic        SPI_SCK, SPI_CS_N, SPI_MOSI, SPI_MISO, SPI_MISO_OE, ok;
    logic        ERASE_REQ, CSD_PROG_REQ, RD_REQ, WR_REQ, GEN_REQ, GEN_DIR;
    logic        CRC_EN, APP_PENDING, ACMD_REQ, CARD_BUSY;
    logic [31:0] ERASE_FIRST, ERASE_LAST, XFER_ADDR, ACMD_ARG;
    logic [9:0]  BLOCK_LEN;
    logic [5:0]  ACMD_INDEX;
    logic [5:0]  req;
    logic [63:0] v;
    logic [5:0]  ill [4] = '{6'h1A, 6'h27, 6'h28, 6'h39};
    int          cnt [6];
    int          failures = 0;
    int          comparisons = 0;
    always #20 CLK_SYS = ~CLK_SYS;
    assign req = {ACMD_REQ, GEN_REQ, WR_REQ, RD_REQ, CSD_PROG_REQ, ERASE_REQ};
    always @(posedge CLK_SYS) begin
        foreach (cnt[i]) cnt[i] <= cnt[i] + int'(req[i] === 1'b1);
    end
    scd_host_model host_u (.SPI_SCK(SPI_SCK), .SPI_CS_N(SPI_CS_N),
        .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO));
    scd_decoder dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .SPI_SCK(SPI_SCK),
        .SPI_CS_N(SPI_CS_N), .SPI_MOSI(SPI_MOSI), .SPI_MISO(SPI_MISO),
        .SPI_MISO_OE(SPI_MISO_OE), .OCR_VALUE(OCR_VALUE), .WR_DONE(WR_DONE),
        .WR_CRC_BAD(WR_CRC_BAD), .PROG_DONE(PROG_DONE),
        .ERASE_REQ(ERASE_REQ), .ERASE_FIRST(ERASE_FIRST),
        .ERASE_LAST(ERASE_LAST),
        .CSD_PROG_REQ(CSD_PROG_REQ), .RD_REQ(RD_REQ), .WR_REQ(WR_REQ),
        .GEN_REQ(GEN_REQ), .GEN_DIR(GEN_DIR), .XFER_ADDR(XFER_ADDR),
        .BLOCK_LEN(BLOCK_LEN), .CRC_EN(CRC_EN), .APP_PENDING(APP_PENDING),
        .ACMD_REQ(ACMD_REQ), .ACMD_INDEX(ACMD_INDEX), .ACMD_ARG(ACMD_ARG),
        .CARD_BUSY(CARD_BUSY));
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic r1(input logic [5:0] c, input logic [31:0] a,
                      input logic [7:0] e);
        host_u.send(c, a);
        host_u.recv(8, v);
        host_u.done();
        check(v, 64'(e));
    endtask : r1
    task automatic pulse(input logic prog);
        @(posedge CLK_SYS);
        PROG_DONE <= prog;
        WR_DONE <= !prog;
        @(posedge CLK_SYS);
        PROG_DONE <= 1'b0;
        WR_DONE <= 1'b0;
    endtask : pulse
    task end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        #1_000_000;
        failures++;
        end_of_test();
    end
    initial begin
        repeat (2) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        repeat (3) @(posedge CLK_SYS);
        check({BLOCK_LEN, CRC_EN, SPI_MISO_OE}, 64'h800);
        host_u.send(CMD_READ_OPERATING_CONDITIONS, 32'h0);
        check(SPI_MISO_OE, 64'h1);
        host_u.recv(40, v);
        host_u.done();
        check(v, {32'h0, OCR_VALUE});
        foreach (ill[i]) r1(ill[i], 32'h0, 8'h04);
        r1(CMD_CRC_OPT, 32'hFFFF_FFFF, 8'h00);
        check(CRC_EN, 64'h1);
        r1(CMD_PROG_CSD, 32'h0, 8'h00);
        check(cnt[1], 64'h1);
        r1(CMD_SET_PROT, 32'h0000_0400, 8'h00);
        r1(CMD_CLR_PROT, 32'h0000_0400, 8'h00);
        check({cnt[0], CARD_BUSY}, 64'h0);
        host_u.send(CMD_QRY_PROT, 32'h0000_0400);
        host_u.recv(64, v);
        host_u.done();
        check(v, 64'h00FE_0000_0000_0000);
        r1(CMD_ERASE, 32'h0, 8'h10);
        r1(CMD_ERASE_FIRST, 32'h0000_0400, 8'h00);
        r1(CMD_ERASE_LAST, 32'h0000_1200, 8'h00);
        check({ERASE_FIRST, ERASE_LAST}, 64'h0400_0000_1200);
        host_u.send(CMD_ERASE, 32'hA5A5_5A5A);
        host_u.recv(16, v);
        check(v, 64'h0);
        check({cnt[0], CARD_BUSY}, 64'h3);
        pulse(1'b1);
        host_u.ready(ok);
        check({ok, CARD_BUSY}, 64'h2);
        r1(CMD_APP_PREFIX, 32'h0, 8'h00);
        check(APP_PENDING, 64'h1);
        r1(6'h29, 32'h4000_0000, 8'h00);
        check({ACMD_INDEX, ACMD_ARG}, {26'h0, 6'h29, 32'h4000_0000});
        check({APP_PENDING, cnt[5]}, 64'h1);
        r1(CMD_CRC_OPT, 32'hFFFF_FFFE, 8'h00);
        check({cnt[5], CRC_EN}, 64'h2);
        for (int d = 1; d >= 0; d--) begin
            r1(CMD_GENERAL, {31'h2AAA_AAAA, d[0]}, 8'h00);
            check({cnt[4], GEN_DIR}, 64'(4 - d));
        end
        r1(CMD_SET_LEN, 32'h0000_0001, 8'h00);
        r1(CMD_SET_LEN, 32'h0000_0201, 8'h40);
        check(BLOCK_LEN, 64'h1);
        r1(CMD_RD_SINGLE, 32'h0000_0A00, 8'h00);
        r1(CMD_WR_SINGLE, 32'h0000_0A00, 8'h40);
        check({cnt[2], cnt[3]}, {32'h1, 32'h0});
        r1(CMD_GO_IDLE, 32'h0, 8'h01);
        check(BLOCK_LEN, 64'h200);
        r1(CMD_SET_LEN, 32'h0000_0200, 8'h00);
        r1(CMD_WR_SINGLE, 32'h0000_0C01, 8'h20);
        host_u.send(CMD_WR_SINGLE, 32'h0000_0C00);
        host_u.recv(8, v);
        check(v, 64'h0);
        check({XFER_ADDR, cnt[3]}, {32'h0C00, 32'h1});
        pulse(1'b0);
        host_u.recv(16, v);
        check({v[15:0], CARD_BUSY}, 64'h0A01);
        pulse(1'b1);
        host_u.ready(ok);
        check({ok, CARD_BUSY}, 64'h2);
        // Bad data CRC: error token and no busy phase
        host_u.send(CMD_WR_SINGLE, 32'h0000_0E00);
        host_u.recv(8, v);
        check(v, 64'h0);
        @(posedge CLK_SYS) WR_CRC_BAD <= 1'b1;
        pulse(1'b0);
        host_u.recv(8, v);
        host_u.done();
        check({v[7:0], CARD_BUSY}, {TOK_DATA_CRC, 1'b0});
        end_of_test();
    end
endmodule : test_scd_decoder
